// [core/cwd_consts.vh]
// constants for the channel 2 window threshold and debounce bank
`ifndef CWD_CONSTS_VH
`define CWD_CONSTS_VH

// register offsets
`define CWD_ADDR_FAST_UNDER  8'h30
`define CWD_ADDR_FAST_OVER   8'h31
`define CWD_ADDR_SLOW_UNDER  8'h32
`define CWD_ADDR_SLOW_OVER   8'h33
`define CWD_ADDR_DEBOUNCE    8'h34
`define CWD_ADDR_CUTOFF      8'h35

// reset values
`define CWD_RST_UNDER        8'h00
`define CWD_RST_OVER         8'hff
`define CWD_RST_DEBOUNCE     8'h00
`define CWD_RST_CUTOFF       3'h4

// settle code fields
`define CWD_OVER_CODE_MSB    7
`define CWD_OVER_CODE_LSB    4
`define CWD_UNDER_CODE_MSB   3
`define CWD_UNDER_CODE_LSB   0
`define CWD_DEB_CAP_CODE     4'ha

// threshold scaling, millivolts
`define CWD_UNITY_BASE_MV    13'h00c8
`define CWD_UNITY_STEP_MV    13'h0005
`define CWD_QUAD_BASE_MV     13'h0320
`define CWD_QUAD_STEP_MV     13'h0014

// timing
`define CWD_CLK_MHZ          100
`define CWD_DEB_MIN_NS       100
`define CWD_DEB_UNIT_CYC     ((`CWD_DEB_MIN_NS * `CWD_CLK_MHZ + 999) / 1000)

// slow path cutoff codes: 2=250 Hz .. 6=4 kHz
`define CWD_CUT_MIN          3'h2
`define CWD_CUT_MAX          3'h6
`define CWD_LPF_FRAC         10

`endif

// [core/cwd_channel.v]
// channel 2 window limits, settle filters and slow path low-pass
`timescale 1ns/1ps
`include "cwd_consts.vh"

module cwd_channel
#(
    parameter [15:0] DEB_UNIT_CYC   = `CWD_DEB_UNIT_CYC,
    parameter [3:0]  LPF_BASE_SHIFT = 4'h4,
    parameter        MV_W           = 13
)
(
    // clock, reset, enable
    input  wire            clk_sys_i,
    input  wire            rstn_i,
    input  wire            ce_i,

    // register port from the management bus engine
    input  wire [7:0]      reg_addr_i,
    input  wire            reg_wr_i,
    input  wire [7:0]      reg_wdata_i,
    input  wire            reg_rd_i,
    output wire [7:0]      reg_rdata_o,

    // scaling, same clock domain
    input  wire            range_scaling_select_i,

    // measured rail, millivolts, same clock domain
    input  wire [MV_W-1:0] fast_mv_i,
    input  wire [MV_W-1:0] slow_mv_i,
    input  wire            slow_valid_i,

    // fault indications
    output wire            fast_under_fault_o,
    output wire            fast_over_fault_o,
    output wire            slow_under_fault_o,
    output wire            slow_over_fault_o,
    output wire [MV_W-1:0] slow_filtered_mv_o
);

    localparam ACC_W = MV_W + `CWD_LPF_FRAC;
    localparam [2:0] CUT_TOP = `CWD_CUT_MAX;

    reg  [7:0]       fast_under_limit_q;
    reg  [7:0]       fast_over_limit_q;
    reg  [7:0]       slow_under_limit_q;
    reg  [7:0]       slow_over_limit_q;
    reg  [7:0]       fast_debounce_times_q;
    reg  [2:0]       slow_path_cutoff_q;

    // read path
    reg  [7:0]       reg_rdata_q;
    reg  [7:0]       rd_mux_d;

    // slow path state
    reg  [ACC_W-1:0] slow_acc_q;
    reg              slow_seeded_q;
    reg              slow_under_q;
    reg              slow_over_q;

    wire             cut_ok;

    // thresholds in millivolts and raw compares
    wire [MV_W-1:0]  fast_under_mv;
    wire [MV_W-1:0]  fast_over_mv;
    wire [MV_W-1:0]  slow_under_mv;
    wire [MV_W-1:0]  slow_over_mv;
    wire [1:0]       fast_raw;
    wire [1:0]       fast_settled;

    // code to millivolt threshold for the active scaling
    function [MV_W-1:0] cwd_code_to_mv;
        input [7:0] code;
        input       quad;
        begin
            if (quad)
            begin
                cwd_code_to_mv = `CWD_QUAD_BASE_MV
                               + {{(MV_W-8){1'b0}}, code} * `CWD_QUAD_STEP_MV;
            end
            else
            begin
                cwd_code_to_mv = `CWD_UNITY_BASE_MV
                               + {{(MV_W-8){1'b0}}, code} * `CWD_UNITY_STEP_MV;
            end
        end
    endfunction

    // invalid cutoff codes are refused and the last valid one stays
    assign cut_ok = (reg_wdata_i[2:0] >= `CWD_CUT_MIN)
                 && (reg_wdata_i[2:0] <= `CWD_CUT_MAX);

    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            fast_under_limit_q    <= `CWD_RST_UNDER;
            fast_over_limit_q     <= `CWD_RST_OVER;
            slow_under_limit_q    <= `CWD_RST_UNDER;
            slow_over_limit_q     <= `CWD_RST_OVER;
            fast_debounce_times_q <= `CWD_RST_DEBOUNCE;
            slow_path_cutoff_q    <= `CWD_RST_CUTOFF;
        end
        else if (ce_i && reg_wr_i)
        begin
            case (reg_addr_i)
                `CWD_ADDR_FAST_UNDER: fast_under_limit_q    <= reg_wdata_i;
                `CWD_ADDR_FAST_OVER:  fast_over_limit_q     <= reg_wdata_i;
                `CWD_ADDR_SLOW_UNDER: slow_under_limit_q    <= reg_wdata_i;
                `CWD_ADDR_SLOW_OVER:  slow_over_limit_q     <= reg_wdata_i;
                `CWD_ADDR_DEBOUNCE:   fast_debounce_times_q <= reg_wdata_i;
                `CWD_ADDR_CUTOFF:
                begin
                    if (cut_ok)
                    begin
                        slow_path_cutoff_q <= reg_wdata_i[2:0];
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // read side; unmapped offsets read zero
    always @*
    begin
        case (reg_addr_i)
            `CWD_ADDR_FAST_UNDER: rd_mux_d = fast_under_limit_q;
            `CWD_ADDR_FAST_OVER:  rd_mux_d = fast_over_limit_q;
            `CWD_ADDR_SLOW_UNDER: rd_mux_d = slow_under_limit_q;
            `CWD_ADDR_SLOW_OVER:  rd_mux_d = slow_over_limit_q;
            `CWD_ADDR_DEBOUNCE:   rd_mux_d = fast_debounce_times_q;
            `CWD_ADDR_CUTOFF:     rd_mux_d = {5'h00, slow_path_cutoff_q};
            default:              rd_mux_d = 8'h00;
        endcase
    end

    // same-cycle write and read of one offset returns the old value
    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            reg_rdata_q <= 8'h00;
        end
        else if (ce_i && reg_rd_i)
        begin
            reg_rdata_q <= rd_mux_d;
        end
    end

    assign reg_rdata_o = reg_rdata_q;

    // thresholds follow the scaling select live, no rewrite needed
    // entry 0 fast under, 1 fast over, 2 slow under, 3 slow over
    wire [31:0]       limit_codes;
    wire [4*MV_W-1:0] limit_mv;

    assign limit_codes = {slow_over_limit_q,
                          slow_under_limit_q,
                          fast_over_limit_q,
                          fast_under_limit_q};

    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1)
        begin : g_limit
            assign limit_mv[k*MV_W +: MV_W] = cwd_code_to_mv(limit_codes[k*8 +: 8],
                                                             range_scaling_select_i);
        end
    endgenerate

    assign fast_under_mv = limit_mv[0*MV_W +: MV_W];
    assign fast_over_mv  = limit_mv[1*MV_W +: MV_W];
    assign slow_under_mv = limit_mv[2*MV_W +: MV_W];
    assign slow_over_mv  = limit_mv[3*MV_W +: MV_W];

    // strict compares: a rail sitting exactly on a limit is in range
    // bit 0 under, bit 1 over
    assign fast_raw[0] = fast_mv_i < fast_under_mv;
    assign fast_raw[1] = fast_mv_i > fast_over_mv;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_settle
            wire [3:0]  code;
            wire [3:0]  capped;
            wire [15:0] target;
            reg         last_q;
            reg  [15:0] cnt_q;
            reg         out_q;

            if (g == 1)
            begin : g_over
                assign code = fast_debounce_times_q[`CWD_OVER_CODE_MSB:`CWD_OVER_CODE_LSB];
            end
            else
            begin : g_under
                assign code = fast_debounce_times_q[`CWD_UNDER_CODE_MSB:`CWD_UNDER_CODE_LSB];
            end

            assign capped = (code > `CWD_DEB_CAP_CODE) ? `CWD_DEB_CAP_CODE : code;
            // a unit above 63 cycles overflows the 16-bit target
            // target is read every cycle, so a new code applies mid-count
            assign target = DEB_UNIT_CYC << capped;

            // symmetric: clearing a fault is filtered the same way as raising it
            always @(posedge clk_sys_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    last_q <= 1'b0;
                    cnt_q  <= 16'h0000;
                    out_q  <= 1'b0;
                end
                else if (ce_i)
                begin
                    if (fast_raw[g] != last_q)
                    begin
                        last_q <= fast_raw[g];
                        cnt_q  <= 16'h0000;
                    end
                    else if (out_q != last_q)
                    begin
                        if (cnt_q + 16'h0001 >= target)
                        begin
                            out_q <= last_q;
                            cnt_q <= 16'h0000;
                        end
                        else
                        begin
                            cnt_q <= cnt_q + 16'h0001;
                        end
                    end
                    else
                    begin
                        cnt_q <= 16'h0000;
                    end
                end
            end

            assign fast_settled[g] = out_q;
        end
    endgenerate

    assign fast_under_fault_o = fast_settled[0];
    assign fast_over_fault_o  = fast_settled[1];

    // slow path first-order low-pass; lower cutoff means a larger shift
    wire [3:0]         lpf_shift;
    wire [ACC_W-1:0]   x_fx;
    wire signed [ACC_W:0] lpf_diff;
    wire signed [ACC_W:0] lpf_step;
    wire [MV_W-1:0]    slow_mv;

    assign lpf_shift = LPF_BASE_SHIFT + {1'b0, CUT_TOP - slow_path_cutoff_q};
    assign x_fx      = {slow_mv_i, {`CWD_LPF_FRAC{1'b0}}};
    assign lpf_diff  = $signed({1'b0, x_fx}) - $signed({1'b0, slow_acc_q});
    assign lpf_step  = lpf_diff >>> lpf_shift;
    assign slow_mv   = slow_acc_q[ACC_W-1:`CWD_LPF_FRAC];

    // seeded from the first sample so no false undervoltage at start
    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            slow_acc_q    <= {ACC_W{1'b0}};
            slow_seeded_q <= 1'b0;
        end
        else if (ce_i && slow_valid_i)
        begin
            slow_seeded_q <= 1'b1;
            if (!slow_seeded_q)
            begin
                slow_acc_q <= x_fx;
            end
            else
            begin
                slow_acc_q <= slow_acc_q + lpf_step[ACC_W-1:0];
            end
        end
    end

    // not settle-filtered: the low-pass already smooths this path
    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            slow_under_q <= 1'b0;
            slow_over_q  <= 1'b0;
        end
        else if (ce_i)
        begin
            slow_under_q <= slow_seeded_q && (slow_mv < slow_under_mv);
            slow_over_q  <= slow_seeded_q && (slow_mv > slow_over_mv);
        end
    end

    assign slow_under_fault_o = slow_under_q;
    assign slow_over_fault_o  = slow_over_q;
    assign slow_filtered_mv_o = slow_mv;

endmodule // cwd_channel

// [test/cwd_channel_monitor.sv]
// checker for the channel 2 threshold and debounce bank
`timescale 1ns/1ps
module cwd_channel_monitor
#(
    parameter MV_W = 13
)
(
    // clock and reset
    input wire            clk_sys_i,
    input wire            rstn_i,
    // register port
    input wire            ce_i,
    input wire [7:0]      reg_addr_i,
    input wire            reg_wr_i,
    input wire [7:0]      reg_wdata_i,
    input wire            reg_rd_i,
    input wire [7:0]      reg_rdata_o,
    // rails and faults
    input wire            range_scaling_select_i,
    input wire [MV_W-1:0] fast_mv_i,
    input wire [MV_W-1:0] slow_mv_i,
    input wire            slow_valid_i,
    input wire            fast_under_fault_o,
    input wire            fast_over_fault_o,
    input wire            slow_under_fault_o,
    input wire            slow_over_fault_o,
    input wire [MV_W-1:0] slow_filtered_mv_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    AST_UNMAPPED: assert property (ce_i && reg_rd_i && !(reg_addr_i inside {[8'h30:8'h35]})
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    AST_CUT_RSVD: assert property (ce_i && reg_rd_i && reg_addr_i == 8'h35
        |=> reg_rdata_o[7:3] == 5'h00) else $error("cutoff upper bits not zero");
    AST_RD_BACK: assert property ((ce_i && reg_wr_i && reg_addr_i inside {[8'h30:8'h34]})
        ##1 !reg_wr_i ##1 (ce_i && reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i, 2))
        |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("read back differs");
    AST_FILT_HOLD: assert property (ce_i && !slow_valid_i |=> $stable(slow_filtered_mv_o))
        else $error("filtered value moved without a sample");
    // limits and scaling feed the compare one cycle later, so three quiet cycles
    AST_SLOW_HOLD: assert property ((!slow_valid_i && !reg_wr_i
        && $stable(range_scaling_select_i))[*3]
        |=> $stable({slow_under_fault_o, slow_over_fault_o})) else $error("slow fault moved");
    AST_FU_MIN: assert property ($changed(fast_under_fault_o)
        |=> $stable(fast_under_fault_o)[*2]) else $error("under fault glitched");
    AST_FO_MIN: assert property ($changed(fast_over_fault_o)
        |=> $stable(fast_over_fault_o)[*2]) else $error("over fault glitched");
endmodule // cwd_channel_monitor

bind cwd_channel cwd_channel_monitor #(.MV_W(MV_W)) i_mon (.*);

// [test/cwd_host_model.sv]
// host model driving the register port
`timescale 1ns/1ps
module cwd_host_model
(
    // clock and read data
    input  wire        clk_sys_i,
    input  wire [7:0]  reg_rdata_i,
    // register strobes
    output logic [7:0] reg_addr_o,
    output logic       reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic       reg_rd_o
);
    initial
    begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    // released lines show the inverse so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
    endtask
endmodule // cwd_host_model

// [test/tb_cwd_channel.sv]
// self-checking bench for the channel 2 threshold and debounce bank
`timescale 1ns/1ps
module tb_cwd_channel;
    logic        clk_sys_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        sc = 1'b0;
    logic        ce = 1'b1;
    logic [12:0] fast_mv = 13'd1000;
    logic [12:0] slow_mv = 13'd0;
    logic        slow_vld = 1'b0;
    wire  [7:0]  addr, wdata, rdata;
    wire         wr, rd, fu, fo, su, so;
    wire  [12:0] filt;
    int          mismatches = 0;
    int          n_compared = 0;
    int          cycles = 0;
    logic [7:0]  d;
    logic [7:0]  rst_tab [7] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h04, 8'h00};

    always #5 clk_sys_i = ~clk_sys_i;

    cwd_host_model i_host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));

    // short settle unit keeps the capped count near two thousand cycles
    cwd_channel #(.DEB_UNIT_CYC(16'd2)) i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .range_scaling_select_i(sc), .fast_mv_i(fast_mv),
        .slow_mv_i(slow_mv), .slow_valid_i(slow_vld), .fast_under_fault_o(fu),
        .fast_over_fault_o(fo), .slow_under_fault_o(su), .slow_over_fault_o(so),
        .slow_filtered_mv_o(filt));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic final_report;
        $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic t_regs;
        for (int i = 0; i < 7; i++)
        begin
            i_host.rd(8'h30 + 8'(i), d);
            chk({5'h00, d}, {5'h00, rst_tab[i]}, "reset value");
        end
        for (int i = 0; i < 5; i++)
        begin
            i_host.wr(8'h30 + 8'(i), 8'h5a ^ 8'(i));
            i_host.rd(8'h30 + 8'(i), d);
            chk({5'h00, d}, {5'h00, 8'h5a ^ 8'(i)}, "read back");
        end
        i_host.wr(8'h35, 8'hff);
        i_host.wr(8'h35, 8'h01);
        i_host.rd(8'h35, d);
        chk({5'h00, d}, 13'h04, "invalid cutoff kept");
        i_host.wr(8'h35, 8'hfa);
        i_host.rd(8'h35, d);
        chk({5'h00, d}, 13'h02, "cutoff 250 Hz");
    endtask

    task automatic t_fast_under;
        i_host.wr(8'h31, 8'hff);
        i_host.wr(8'h34, 8'h02);
        i_host.wr(8'h30, 8'd100);
        tick(70);
        chk({12'h000, fo}, 13'h0, "over fault idle");
        fast_mv = 13'd699;
        tick(4);
        fast_mv = 13'd700;
        tick(4);
        chk({12'h000, fu}, 13'h0, "boundary not under");
        fast_mv = 13'd699;
        tick(8);
        chk({12'h000, fu}, 13'h0, "under too early");
        tick(1);
        chk({12'h000, fu}, 13'h1, "under after code 2");
    endtask

    task automatic t_fast_over;
        fast_mv = 13'd1000;
        sc = 1'b1;
        i_host.wr(8'h30, 8'h00);
        i_host.wr(8'h34, 8'hf2);
        i_host.wr(8'h31, 8'd10);
        tick(20);
        chk({12'h000, fu}, 13'h0, "under cleared");
        fast_mv = 13'd1001;
        tick(2048);
        chk({12'h000, fo}, 13'h0, "over too early");
        tick(1);
        chk({12'h000, fo}, 13'h1, "over after cap");
        chk({12'h000, fu}, 13'h0, "under independent");
    endtask

    task automatic t_slow;
        i_host.wr(8'h32, 8'd10);
        i_host.wr(8'h33, 8'd60);
        tick(1);
        slow_mv = 13'd999;
        slow_vld = 1'b1;
        tick(1);
        slow_vld = 1'b0;
        chk(filt, 13'd999, "first sample loads");
        tick(1);
        chk({11'h000, su, so}, 13'h2, "slow faults");
        i_host.wr(8'h35, 8'h06);
        i_host.wr(8'h33, 8'h05);
        ce = 1'b0;
        slow_mv = 13'd1159;
        slow_vld = 1'b1;
        tick(2);
        chk(filt, 13'd999, "frozen while disabled");
        ce = 1'b1;
        tick(1);
        slow_vld = 1'b0;
        chk(filt, 13'd1009, "step at 4 kHz cutoff");
        tick(1);
        chk({11'h000, su, so}, 13'h1, "slow over only");
    endtask

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            mismatches++;
            final_report();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        t_regs();
        t_fast_under();
        t_fast_over();
        t_slow();
        final_report();
    end
endmodule // tb_cwd_channel
